// file: event_flag_combiner.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - one occurrence flag per event, reads 1 once the event has arrived.
// - flags are read-only to the bus and reset to zero.
// - a one written to a force-set bit sets that flag; zero leaves it.
// - force-set and clear registers are write-only with no readable state.
// - a one written to a clear bit clears that flag; zero leaves it.
// - combine-mask bit 0 includes the event in its group, 1 excludes it.
// - mask bits reset to 0 and are read/write, except group 0 bits 3:0 fixed 1.
// - masked-flag bit equals the flag when mask is 0, else reads 0.
// - four masked-flag views are read-only and read zero after reset.
// - up to 32 events of one group merge into one combined output.
// - exactly four combined outputs, numbered 0 to 3.
// - a set flag stays 1 until an explicit clear.
// - flags 0 to 3 have no input and always read 0.
module event_flag_combiner
   import event_flag_combiner_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // system events, level high marks an arrival
   input wire logic [127:0] SYSTEM_EVENT_IN,
   // combined outputs and interrupt
   output logic [3:0] COMBINED_EVENT_OUT,
   output logic IRQ
);

   logic [127:0] occurrence_flag_reg;
   logic [127:0] occurrence_flag_next;
   logic [127:0] combine_mask_reg;
   logic [127:0] combine_mask_next;
   logic [127:0] masked_flag_view;
   logic [3:0] group_any;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_status_next;
   logic [3:0] irq_mask_reg;
   logic [3:0] irq_mask_next;
   logic [3:0] combined_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_mux;

   // word index and group slice helpers
   function automatic logic [127:0] spread(input logic [1:0] grp, input logic [31:0] val);
      spread = 128'(val) << (32 * grp);
   endfunction

   function automatic logic [31:0] slice(input logic [127:0] v, input logic [1:0] grp);
      slice = v[32 * grp +: 32];
   endfunction

   // apb decode; every access completes in its first access cycle
   wire access = PSEL & PENABLE;
   wire wr_fire = access & PWRITE;
   wire rd_fire = access & ~PWRITE;
   wire setup_rd = PSEL & ~PENABLE & ~PWRITE;
   wire [1:0] grp = PADDR[3:2];
   wire [7:0] base = {PADDR[7:4], 4'h0};
   wire aligned = (PADDR[1:0] == 2'b00);
   wire hit_flag = aligned & (base == OFS_FLAG_BASE);
   wire hit_set = aligned & (base == OFS_SET_BASE);
   wire hit_clr = aligned & (base == OFS_CLEAR_BASE);
   wire hit_mask = aligned & (base == OFS_MASK_BASE);
   wire hit_mview = aligned & (base == OFS_MVIEW_BASE);
   wire hit_ists = aligned & (PADDR == OFS_IRQ_STATUS);
   wire hit_imsk = aligned & (PADDR == OFS_IRQ_MASK);
   wire mapped = hit_flag | hit_set | hit_clr | hit_mask | hit_mview | hit_ists | hit_imsk;

   // write strobes spread to event positions; writes to flag or view are dropped
   wire [127:0] set_vec = (wr_fire & hit_set) ? spread(grp, PWDATA) : '0;
   wire [127:0] clr_vec = (wr_fire & hit_clr) ? spread(grp, PWDATA) : '0;
   wire [127:0] rsvd_vec = 128'(RSVD_LOW_BITS);

   // flag update: arrival or force sets, clear clears, set wins over clear
   // so that an event landing on a clear cycle is not lost
   assign occurrence_flag_next = ((occurrence_flag_reg & ~clr_vec)
      | SYSTEM_EVENT_IN | set_vec) & ~rsvd_vec;

   // mask update; group 0 bits 3:0 forced to one
   assign combine_mask_next = ((wr_fire & hit_mask)
      ? ((combine_mask_reg & ~spread(grp, 32'hFFFFFFFF)) | spread(grp, PWDATA))
      : combine_mask_reg) | rsvd_vec;

   // masked view and group merge
   assign masked_flag_view = occurrence_flag_reg & ~combine_mask_reg;
   always_comb begin
      for (int g = 0; g < GROUPS; g++) begin
         group_any[g] = |slice(masked_flag_view, 2'(g));
      end
   end

   // interrupt status: rising combined output is the event, read clears,
   // but a new event in the read cycle survives
   wire [3:0] rise = group_any & ~combined_reg;
   wire ists_read = rd_fire & hit_ists;
   // only the bits the read returned are cleared, so a rise after setup is kept
   assign irq_status_next = (irq_status_reg & ~(ists_read ? prdata_reg[3:0] : 4'h0)) | rise;
   assign irq_mask_next = (wr_fire & hit_imsk) ? PWDATA[3:0] : irq_mask_reg;

   // read mux; write-only set and clear read zero
   always_comb begin
      rdata_mux = 32'h00000000;
      if (hit_flag) begin
         rdata_mux = slice(occurrence_flag_reg, grp);
      end else if (hit_mask) begin
         rdata_mux = slice(combine_mask_reg, grp);
      end else if (hit_mview) begin
         rdata_mux = slice(masked_flag_view, grp);
      end else if (hit_ists) begin
         rdata_mux = {28'h0000000, irq_status_reg};
      end else if (hit_imsk) begin
         rdata_mux = {28'h0000000, irq_mask_reg};
      end else begin
         rdata_mux = 32'h00000000;
      end
   end

   // state registers
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         occurrence_flag_reg <= '0;
         combine_mask_reg <= rsvd_vec;
         irq_status_reg <= 4'h0;
         irq_mask_reg <= IRQ_MASK_RESET;
         combined_reg <= 4'h0;
      end else begin
         occurrence_flag_reg <= occurrence_flag_next;
         combine_mask_reg <= combine_mask_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         combined_reg <= group_any;
      end
   end

   // read data loaded in the setup cycle so it stands from a flop through access;
   // a flag that moves between setup and access shows on the next read
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         prdata_reg <= 32'h00000000;
      end else begin
         prdata_reg <= setup_rd ? rdata_mux : 32'h00000000;
      end
   end

   // outputs; read data is zero outside a read access
   assign PRDATA = prdata_reg;
   assign PREADY = 1'b1;
   assign PSLVERR = access & ~mapped;
   assign COMBINED_EVENT_OUT = combined_reg;
   assign IRQ = |(irq_status_reg & ~irq_mask_reg);

   // assertions
   sequence set_write_s(int b, int g);
      wr_fire && hit_set && grp == 2'(g) && PWDATA[b];
   endsequence

   sequence clr_write_s(int b, int g);
      wr_fire && hit_clr && grp == 2'(g) && PWDATA[b];
   endsequence

   sequence rd_setup_s;
      PSEL && !PENABLE && !PWRITE;
   endsequence

   flag_sticky_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      occurrence_flag_reg[40] && !clr_vec[40] |=> occurrence_flag_reg[40])
      else $error("flag dropped without a clear");

   flag_arrive_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      SYSTEM_EVENT_IN[77] |=> occurrence_flag_reg[77])
      else $error("arrival not captured");

   force_set_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      set_write_s(5, 1) |=> occurrence_flag_reg[37])
      else $error("force set ignored");

   flag_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (clr_vec[100] && !set_vec[100] && !SYSTEM_EVENT_IN[100]) |=> !occurrence_flag_reg[100])
      else $error("clear ignored");

   low_reserved_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      occurrence_flag_reg[3:0] == 4'h0 && combine_mask_reg[3:0] == 4'hF)
      else $error("reserved low bits disturbed");

   mview_rule_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      combine_mask_reg[64] |-> !masked_flag_view[64])
      else $error("masked bit visible");

   combine_out_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (occurrence_flag_reg[96] && !combine_mask_reg[96]) |=> COMBINED_EVENT_OUT[3])
      else $error("combined output missing");

   combine_idle_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (slice(masked_flag_view, 2'd2) == 32'h0) |=> !COMBINED_EVENT_OUT[2])
      else $error("combined output without cause");

   set_then_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      set_write_s(9, 0) ##1 (PSEL && !PENABLE && !PWRITE && hit_flag && grp == 2'd0)
      ##1 rd_fire |-> PRDATA[9])
      else $error("flag read misses forced bit");

   wo_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (rd_fire && (hit_set || hit_clr)) |-> PRDATA == 32'h0)
      else $error("write-only register returned data");

   // access returns what the mux showed in setup
   rd_capture_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      rd_setup_s ##1 rd_fire |-> PRDATA == $past(rdata_mux))
      else $error("read data not held from setup");

   // writes to the flag or view words must leave every flag alone
   flag_wr_ignore_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && (hit_flag || hit_mview) && SYSTEM_EVENT_IN == '0)
      |=> occurrence_flag_reg == $past(occurrence_flag_reg))
      else $error("flag changed by a write to a read-only word");

   // flag word read returns the flags of that group
   flag_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      rd_setup_s ##1 (rd_fire && hit_flag && grp == 2'd3)
      |-> PRDATA == $past(occurrence_flag_reg[127:96]))
      else $error("flag read wrong");

   // a zero in a force-set word leaves a clear flag clear
   set_zero_keeps_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_set && grp == 2'd2 && !PWDATA[7] && !occurrence_flag_reg[71]
      && !SYSTEM_EVENT_IN[71]) |=> !occurrence_flag_reg[71])
      else $error("zero in set word set a flag");

   // every one of a force-set word lands, reserved bits excepted
   set_all_bits_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_set)
      |=> (occurrence_flag_reg & $past(set_vec)) == ($past(set_vec) & ~rsvd_vec))
      else $error("force set lost a bit");

   // a zero in a clear word leaves a set flag set
   clr_zero_keeps_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_clr && grp == 2'd3 && !PWDATA[0] && occurrence_flag_reg[96])
      |=> occurrence_flag_reg[96])
      else $error("zero in clear word cleared a flag");

   // every one of a clear word clears, when no arrival competes
   clr_all_bits_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_clr && SYSTEM_EVENT_IN == '0)
      |=> (occurrence_flag_reg & $past(clr_vec)) == '0)
      else $error("clear missed a bit");

   // top flag cleared through its own word
   clear_seq_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      clr_write_s(31, 3) ##0 !SYSTEM_EVENT_IN[127] |=> !occurrence_flag_reg[127])
      else $error("top flag not cleared");

   // an arrival in the clear cycle wins, so the event is not lost
   set_wins_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      clr_write_s(18, 1) ##0 SYSTEM_EVENT_IN[50] |=> occurrence_flag_reg[50])
      else $error("arrival lost to a clear");

   // a forced flag survives eight cycles without a clear
   sticky_run_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      set_write_s(31, 3) ##1 (!clr_vec[127]) [*8] |=> occurrence_flag_reg[127])
      else $error("forced flag decayed");

   // set and clear words hold no state of their own
   wo_no_state_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && (hit_set || hit_clr))
      |=> combine_mask_reg == $past(combine_mask_reg))
      else $error("write-only word changed the mask");

   // mask word write lands in its group
   mask_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_mask && grp == 2'd1)
      |=> combine_mask_reg[63:32] == $past(PWDATA))
      else $error("mask write lost");

   // group 0 mask write keeps the fixed ones
   mask_fixed_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (wr_fire && hit_mask && grp == 2'd0) |=> combine_mask_reg[31:4] == $past(PWDATA[31:4])
      && combine_mask_reg[3:0] == 4'hF)
      else $error("group 0 mask write wrong");

   // masks move only on a mask write
   mask_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      !(wr_fire && hit_mask) |=> combine_mask_reg == $past(combine_mask_reg))
      else $error("mask changed without a write");

   // reset values of the masks
   reset_mask_a: assert property (@(posedge REF_CLK)
      $past(RESET) |-> combine_mask_reg == rsvd_vec)
      else $error("mask reset value wrong");

   // an open event shows its flag in the view
   view_equal_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      !combine_mask_reg[127] |-> masked_flag_view[127] == occurrence_flag_reg[127])
      else $error("view differs from open flag");

   // view word read is the masked flags of the group
   view_read_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      rd_setup_s ##1 (rd_fire && hit_mview && grp == 2'd1) |-> PRDATA
      == ($past(occurrence_flag_reg[63:32]) & ~$past(combine_mask_reg[63:32])))
      else $error("view read wrong");

   // flags, views and outputs are zero straight after reset
   reset_clear_a: assert property (@(posedge REF_CLK)
      $past(RESET) |-> occurrence_flag_reg == '0 && masked_flag_view == '0
      && COMBINED_EVENT_OUT == 4'h0)
      else $error("reset state wrong");

   // an arrival on a reserved input leaves its flag at zero
   reserved_arrival_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      SYSTEM_EVENT_IN[2] |=> !occurrence_flag_reg[2])
      else $error("reserved flag set");

   // any open flag of group 0 raises output 0 next cycle
   group0_out_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (|masked_flag_view[31:0]) |=> COMBINED_EVENT_OUT[0])
      else $error("group 0 output missing");

   // up to 32 open flags of group 1 merge into output 1
   group1_out_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (|masked_flag_view[63:32]) |=> COMBINED_EVENT_OUT[1])
      else $error("group 1 output missing");

   // output 3 never stands without a cause one cycle earlier
   group3_cause_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      COMBINED_EVENT_OUT[3] |-> $past(|masked_flag_view[127:96]))
      else $error("output 3 without cause");

   // a rising group output is recorded in the status
   status_rise_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      rise[1] |=> irq_status_reg[1])
      else $error("status missed a rise");

   // a read clears the status bits it returned
   status_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (ists_read && prdata_reg[0] && !rise[0]) |=> !irq_status_reg[0])
      else $error("status not cleared by read");

   // a rise in the read cycle survives the read
   status_keep_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (ists_read && rise[2]) |=> irq_status_reg[2])
      else $error("rise lost to status read");

   // all groups masked keeps the interrupt low
   irq_masked_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (irq_mask_reg == 4'hF) |-> !IRQ)
      else $error("interrupt through full mask");

   // unaligned access reports an error
   slverr_unaligned_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      (access && !aligned) |-> PSLVERR)
      else $error("unaligned access not flagged");

   // error response stands only in an access cycle
   slverr_idle_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      !access |-> !PSLVERR)
      else $error("error outside access");

   // read data is zero while the bus is idle
   prdata_idle_a: assert property (@(posedge REF_CLK) disable iff (RESET)
      !PSEL |-> PRDATA == 32'h00000000)
      else $error("read data on idle bus");

endmodule

`default_nettype wire

// file: event_flag_combiner_pkg.sv
package event_flag_combiner_pkg;
   // register byte offsets, one aligned word each, group index in bits 3:2
   localparam logic [7:0] OFS_FLAG_BASE = 8'h00;
   localparam logic [7:0] OFS_SET_BASE = 8'h20;
   localparam logic [7:0] OFS_CLEAR_BASE = 8'h40;
   localparam logic [7:0] OFS_MASK_BASE = 8'h80;
   localparam logic [7:0] OFS_MVIEW_BASE = 8'hA0;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
   localparam logic [7:0] OFS_IRQ_MASK = 8'hF4;
   // geometry
   localparam int GROUPS = 4;
   localparam int GROUP_BITS = 32;
   localparam int EVENTS = 128;
   // reserved low flags and the mask bits fixed at one
   localparam logic [31:0] RSVD_LOW_BITS = 32'h0000000F;
   localparam logic [31:0] MASK_RESET = 32'h00000000;
   localparam logic [31:0] FLAG_RESET = 32'h00000000;
   localparam logic [3:0] IRQ_MASK_RESET = 4'hF;
endpackage

// file: event_flag_combiner_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module event_flag_combiner_tb_top;
   import event_flag_combiner_pkg::*;
   logic clk, rst, psel, pen, pwr, pready, err, fire;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [127:0] ev;
   logic [6:0] num;
   logic [3:0] cev;
   logic irq;
   int mismatches, checked;
   event_flag_combiner dut_u (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(err), .SYSTEM_EVENT_IN(ev), .COMBINED_EVENT_OUT(cev), .IRQ(irq));
   event_source src_u (.clk(clk), .fire(fire), .num(num), .ev(ev));
   // 40 ns period
   always #20 clk = ~clk;
   task automatic print_verdict;
      $display("counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // apb cycle: hold setup, then access until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pen <= 1'b0;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   function automatic logic [7:0] ad(input logic [7:0] b, input int g);
      return b + 8'(4 * g);
   endfunction
   task automatic t_reset;
      for (int g = 0; g < 4; g++) begin
         rd(ad(OFS_FLAG_BASE, g), 32'h0);
         rd(ad(OFS_MASK_BASE, g), (g == 0) ? 32'hF : 32'h0);
         rd(ad(OFS_MVIEW_BASE, g), 32'h0);
      end
      chk(32'(cev), 32'h0);
      $display("end reset");
   endtask
   task automatic pulse(input logic [6:0] n);
      @(posedge clk);
      fire <= 1'b1; num <= n;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // event 37 sits in group 1 bit 5; event 2 is reserved
   task automatic t_event;
      pulse(7'd37);
      pulse(7'd2);
      rd(ad(OFS_FLAG_BASE, 1), 32'h20);
      rd(ad(OFS_FLAG_BASE, 0), 32'h0);
      rd(ad(OFS_MVIEW_BASE, 1), 32'h20);
      chk(32'(cev), 32'h2);
      xfer(1'b1, ad(OFS_CLEAR_BASE, 1), 32'h20);
      rd(ad(OFS_FLAG_BASE, 1), 32'h0);
      repeat (2) @(posedge clk);
      chk(32'(cev), 32'h0);
      $display("end event");
   endtask
   task automatic t_force;
      xfer(1'b1, ad(OFS_SET_BASE, 3), 32'h80000001);
      xfer(1'b1, ad(OFS_SET_BASE, 3), 32'h0);
      rd(ad(OFS_SET_BASE, 3), 32'h0);
      xfer(1'b1, ad(OFS_FLAG_BASE, 3), 32'h0);
      xfer(1'b1, ad(OFS_CLEAR_BASE, 3), 32'h0);
      rd(ad(OFS_FLAG_BASE, 3), 32'h80000001);
      xfer(1'b1, ad(OFS_MASK_BASE, 3), 32'h7FFFFFFF);
      rd(ad(OFS_MVIEW_BASE, 3), 32'h80000000);
      chk(32'(cev), 32'h8);
      xfer(1'b1, ad(OFS_MASK_BASE, 3), 32'hFFFFFFFF);
      repeat (2) @(posedge clk);
      chk(32'(cev), 32'h0);
      rd(ad(OFS_MVIEW_BASE, 3), 32'h0);
      xfer(1'b1, ad(OFS_CLEAR_BASE, 3), 32'hFFFFFFFF);
      xfer(1'b1, ad(OFS_MASK_BASE, 3), 32'h0);
      $display("end force");
   endtask
   task automatic t_mask;
      xfer(1'b1, ad(OFS_MASK_BASE, 0), 32'h0);
      rd(ad(OFS_MASK_BASE, 0), 32'hF);
      xfer(1'b1, ad(OFS_MASK_BASE, 2), 32'hA5A5A5A5);
      rd(ad(OFS_MASK_BASE, 2), 32'hA5A5A5A5);
      xfer(1'b1, ad(OFS_MASK_BASE, 2), 32'h0);
      $display("end mask");
   endtask
   // group 1 interrupt masked, group 0 open; status still records both
   task automatic t_irq;
      xfer(1'b0, OFS_IRQ_STATUS, 32'h0);
      xfer(1'b1, OFS_IRQ_MASK, 32'h2);
      chk(32'(irq), 32'h0);
      xfer(1'b1, ad(OFS_SET_BASE, 1), 32'h1);
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h0);
      xfer(1'b1, ad(OFS_SET_BASE, 0), 32'h10);
      repeat (4) @(posedge clk);
      chk(32'(irq), 32'h1);
      rd(OFS_IRQ_STATUS, 32'h3);
      @(posedge clk);
      chk(32'(irq), 32'h0);
      xfer(1'b1, ad(OFS_CLEAR_BASE, 0), 32'h10);
      xfer(1'b1, ad(OFS_CLEAR_BASE, 1), 32'h1);
      $display("end irq");
   endtask
   task automatic t_bad;
      xfer(1'b0, 8'h60, 32'h0);
      chk(q, 32'h0);
      chk(32'(err), 32'h1);
      xfer(1'b0, 8'h02, 32'h0);
      chk(32'(err), 32'h1);
      xfer(1'b0, OFS_MASK_BASE, 32'h0);
      chk(32'(err), 32'h0);
      $display("end unmapped");
   endtask
   initial begin
      clk = 1'b0; rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; fire = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; num = 7'h00; mismatches = 0; checked = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_event;
      t_force;
      t_mask;
      t_irq;
      t_bad;
      print_verdict;
   end
   // watchdog well beyond the roughly 165 cycles the tests take
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire

// file: event_source.sv
`timescale 1ns/1ps
`default_nettype none
module event_source (
   input wire logic clk,
   input wire logic fire,
   input wire logic [6:0] num,
   output logic [127:0] ev
);
   // one-cycle arrival pulse, so a flag seen later proves it latched
   always_ff @(posedge clk) begin
      ev <= fire ? (128'h1 << num) : 128'h0;
   end
endmodule
`default_nettype wire
